// file: hdl/aux_master_pkg.sv
// Overview of operation
// - I2C mode uses data pin SDA, clock pin SCL
// - SPI mode: select, data, clock pins as CS/DATA/CLK
// - SPI is mode 3: idle high, rising-edge sample
// - Pins only pull low, never drive high
// - Buffer holds three slots of lead/data/trail
// - Lead code bit 3 selects SPI or I2C
// - I2C lead 0110: START then send byte
// - I2C lead 0001: generate STOP
// - I2C lead 0000: send byte directly
// - I2C lead 0111: release lines, ignore slot
// - I2C trail 0000 ACK, 1000 NACK on ninth
// - I2C trail 1001: NACK then STOP
// - SPI lead 1000: chip select low first
// - SPI lead 1010: chip select high then low
// - SPI lead 1001: chip select high
// - SPI lead 1111: release pins, ignore slot
// - SPI trail X000: keep chip select low
// - SPI trail 1001: chip select high after byte
// - Transfer advances only on 24 host clocks/byte
// - Bytes sent out, received bytes stored back
// - Bad check code: buffer set to ones
// - SPI readback codes are 0111 and 1111
package aux_master_pkg;
  // Buffer geometry: three slots of two bytes each
  localparam int unsigned SLOT_COUNT  = 3;
  localparam int unsigned BUFFER_SIZE = 6;
  // Byte index of each buffer register
  localparam logic [2:0] IDX_BUS_SLOT0_LEAD_HI  = 3'h0;
  localparam logic [2:0] IDX_BUS_SLOT0_LO_TRAIL = 3'h1;
  localparam logic [2:0] IDX_BUS_SLOT1_LEAD_HI  = 3'h2;
  localparam logic [2:0] IDX_BUS_SLOT1_LO_TRAIL = 3'h3;
  localparam logic [2:0] IDX_BUS_SLOT2_LEAD_HI  = 3'h4;
  localparam logic [2:0] IDX_BUS_SLOT2_LO_TRAIL = 3'h5;
  // Value of every buffer byte after reset and after a failed check
  localparam logic [7:0] BUFFER_RESET = 8'hff;
  // Field positions inside a slot byte pair
  localparam int unsigned LEAD_MSB = 7;
  localparam int unsigned LEAD_LSB = 4;
  localparam int unsigned MODE_BIT = 7;
  // Host clock cycles per slot and the last phase of a slot
  localparam logic [4:0] CYCLES_PER_SLOT = 5'h18;
  localparam logic [4:0] PHASE_LAST      = 5'h17;
  localparam logic [1:0] SLOT_LAST       = 2'h2;
  // I2C phase plan: condition phases, bit window, tail phases
  localparam logic [4:0] I2C_BIT_FIRST = 5'h03;
  localparam logic [4:0] I2C_SAMPLE_LO = 5'h06;
  localparam logic [4:0] I2C_TAIL0     = 5'h15;
  localparam logic [4:0] I2C_TAIL1     = 5'h16;
  localparam logic [4:0] I2C_TAIL2     = 5'h17;
  // SPI phase plan
  localparam logic [4:0] SPI_BIT_FIRST = 5'h02;
  localparam logic [4:0] SPI_BIT_LAST  = 5'h11;
  localparam logic [4:0] SPI_SAMPLE_LO = 5'h05;
  localparam logic [4:0] SPI_SAMPLE_HI = 5'h13;
  localparam logic [4:0] SPI_TAIL      = 5'h12;
  // Leading codes, I2C
  localparam logic [3:0] I2C_START  = 4'h6;
  localparam logic [3:0] I2C_STOP   = 4'h1;
  localparam logic [3:0] I2C_BLANK  = 4'h0;
  localparam logic [3:0] I2C_NOTX   = 4'h7;
  // Trailing codes, I2C
  localparam logic [3:0] I2C_ACK       = 4'h0;
  localparam logic [3:0] I2C_NACK      = 4'h8;
  localparam logic [3:0] I2C_NACK_STOP = 4'h9;
  // Trailing readback codes, I2C
  localparam logic [3:0] RB_SLAVE_ACK       = 4'h7;
  localparam logic [3:0] RB_SLAVE_NACK      = 4'hf;
  localparam logic [3:0] RB_ACK_STOP        = 4'h1;
  localparam logic [3:0] RB_NACK_STOP       = 4'h9;
  // Leading codes, SPI
  localparam logic [3:0] SPI_CS_LOW  = 4'h8;
  localparam logic [3:0] SPI_CS_FALL = 4'ha;
  localparam logic [3:0] SPI_CS_HIGH = 4'h9;
  localparam logic [3:0] SPI_NOTX    = 4'hf;
  // Trailing code, SPI (X000 is matched on bits 2:0)
  localparam logic [3:0] SPI_TR_CS_HIGH = 4'h9;
  // Readback codes, SPI
  localparam logic [3:0] SPI_RB_LEAD  = 4'h7;
  localparam logic [3:0] SPI_RB_TRAIL = 4'hf;
endpackage

// file: hdl/aux_i2c_spi_master.sv
`timescale 1ns/1ps
module aux_i2c_spi_master (
  input  wire logic       sys_clk_in,              // System clock, 50 MHz
  input  wire logic       sys_rst_in,              // Async reset, active high
  input  wire logic       buf_wr_en_in,            // Write one buffer byte
  input  wire logic [2:0] buf_wr_index_in,         // Byte index for write
  input  wire logic [7:0] buf_wr_data_in,          // Byte to write
  input  wire logic       check_fail_in,           // Packet check code mismatched
  input  wire logic [2:0] buf_rd_index_in,         // Byte index for read
  output logic      [7:0] buf_rd_data_out,         // Registered read data
  input  wire logic       start_bus_transfer_in,   // Start transfer pulse
  output logic            busy_out,                // Transfer in progress
  input  wire logic       host_clk_in,             // Primary-port clock (link domain)
  input  wire logic       host_port_select_n_in,   // Primary-port select, low active
  input  wire logic       select_out_pin_in,       // Select pin level
  output logic            select_out_pin_out,      // Select pin drive value
  output logic            select_out_pin_oe_out,   // Select pin pull-low enable
  input  wire logic       data_io_pin_in,          // Data pin level
  output logic            data_io_pin_out,         // Data pin drive value
  output logic            data_io_pin_oe_out,      // Data pin pull-low enable
  input  wire logic       clock_out_pin_in,        // Clock pin level
  output logic            clock_out_pin_out,       // Clock pin drive value
  output logic            clock_out_pin_oe_out     // Clock pin pull-low enable
);
  import aux_master_pkg::*;

  // ---------------- System domain ----------------
  logic [7:0] bus_master_buffer [BUFFER_SIZE];  // Six-byte buffer, layout
  logic       start_tgl;                        // Start event as a toggle
  logic       check_pending;                    // Bad check seen, waits for select high
  logic [2:0] sel_sys;                          // Select sync: two stages plus edge
  logic [2:0] done_sys;                         // Done toggle sync plus edge
  logic       sel_rise;                         // Host select went high
  logic       done_evt;                         // One slot result arrived
  // Link-domain results, held stable for a whole slot
  logic       done_tgl;
  logic [1:0] done_slot;
  logic [7:0] res_hi;
  logic [7:0] res_lo;

  assign sel_rise = sel_sys[1] & ~sel_sys[2];
  assign done_evt = done_sys[1] ^ done_sys[2];

  // Synchronisers into the system clock; first stage feeds only the second
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sel_sys  <= 3'h7;
      done_sys <= 3'h0;
    end else begin
      sel_sys  <= {sel_sys[1:0], host_port_select_n_in};
      done_sys <= {done_sys[1:0], done_tgl};
    end
  end

  // Check failure latches until the host releases select; a new failure
  // in the release cycle wins so it is never lost
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      check_pending <= 1'b0;
    end else if (check_fail_in) begin
      check_pending <= 1'b1;
    end else if (sel_rise) begin
      check_pending <= 1'b0;
    end
  end

  // Buffer writes: fill on failed check first, then slot results, then host
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < BUFFER_SIZE; i++) begin
        bus_master_buffer[i] <= BUFFER_RESET;
      end
    end else if (sel_rise && check_pending) begin
      for (int i = 0; i < BUFFER_SIZE; i++) begin
        bus_master_buffer[i] <= BUFFER_RESET;
      end
    end else if (done_evt) begin
      bus_master_buffer[{done_slot, 1'b0}] <= res_hi;
      bus_master_buffer[{done_slot, 1'b1}] <= res_lo;
    end else if (buf_wr_en_in && buf_wr_index_in < 3'(BUFFER_SIZE)) begin
      bus_master_buffer[buf_wr_index_in] <= buf_wr_data_in;
    end
  end

  // Registered readback; out-of-range indices read zero
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buf_rd_data_out <= 8'h00;
    end else if (buf_rd_index_in < 3'(BUFFER_SIZE)) begin
      buf_rd_data_out <= bus_master_buffer[buf_rd_index_in];
    end else begin
      buf_rd_data_out <= 8'h00;
    end
  end

  // Start toggle and busy flag; busy drops when the last slot lands
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      start_tgl <= 1'b0;
      busy_out  <= 1'b0;
    end else if (start_bus_transfer_in) begin
      start_tgl <= ~start_tgl;
      busy_out  <= 1'b1;
    end else if (done_evt && done_slot == SLOT_LAST) begin
      busy_out  <= 1'b0;
    end
  end

  // ---------------- Link domain (host clock) ----------------
  // The host clock stops outside frames, so every action below except the synchronisers
  // and the start arm is tied to a counted host edge and nothing waits for an edge after the last.
  logic [2:0] arm_s;        // Start toggle sync plus edge stage
  logic [1:0] sel_s;        // Select sync
  logic [1:0] din_s;        // Data pin sync
  logic       active;       // Transfer running
  logic [1:0] slot;         // Current slot
  logic [4:0] phase;        // Host cycle within slot
  logic       skip;         // Rest of slot ignored
  logic [7:0] rx;           // Received byte
  logic       ack_bit;      // Level seen on ninth I2C clock
  logic       cs_low;       // Pull select pin low
  logic       sda_low;      // Pull data pin low
  logic       scl_low;      // Pull clock pin low
  logic       step;         // Counted host cycle
  logic       arm_evt;      // Start seen in link domain
  logic [3:0] lead;         // Leading code of slot
  logic [3:0] trail;        // Trailing code of slot
  logic [7:0] data;         // Payload of slot
  logic       spi_mode;     // Slot runs as SPI
  logic [4:0] i2c_off;      // Phase offset into I2C bit window
  logic [4:0] spi_off;      // Phase offset into SPI bit window
  logic [3:0] i2c_bit;      // I2C bit number 0..8
  logic [2:0] spi_bit;      // SPI bit number 0..7
  logic       in_i2c_bits;  // Inside I2C nine-bit window
  logic       in_spi_bits;  // Inside SPI eight-bit window
  logic       i2c_sample;   // Sample previous I2C bit
  logic       spi_sample;   // Sample previous SPI bit
  logic [3:0] i2c_trail_rb; // I2C trailing readback code
  // Whole slot bytes, split into fields below
  logic [7:0] head_byte;    // Lead code and high data nibble
  logic [7:0] tail_byte;    // Low data nibble and trail code

  // Slot fields; the buffer is quiet during a transfer except for slots
  // already finished, so reading it here is safe
  function automatic logic [7:0] byte_at(input logic [1:0] s, input logic lo);
    byte_at = bus_master_buffer[{s, lo}];
  endfunction

  // Slot index three after the last slot reads past the buffer; unused while idle
  assign head_byte = byte_at(slot, 1'b0);
  assign tail_byte = byte_at(slot, 1'b1);
  assign lead     = head_byte[LEAD_MSB:LEAD_LSB];
  assign data     = {head_byte[3:0], tail_byte[7:4]};
  assign trail    = tail_byte[3:0];
  assign spi_mode = head_byte[MODE_BIT];

  assign step    = active & ~sel_s[1];
  assign arm_evt = arm_s[1] ^ arm_s[2];

  assign i2c_off     = phase - I2C_BIT_FIRST;
  assign spi_off     = phase - SPI_BIT_FIRST;
  assign i2c_bit     = i2c_off[4:1];
  assign spi_bit     = spi_off[3:1];
  assign in_i2c_bits = phase >= I2C_BIT_FIRST && phase < I2C_TAIL0;
  assign in_spi_bits = phase >= SPI_BIT_FIRST && phase <= SPI_BIT_LAST;
  // The pin synchroniser lags two edges, so a bit is taken two edges after
  // the edge that released the clock, which saw the level the slave took.
  // One edge earlier would catch the previous bit's level and the received
  // byte would slip by one bit.
  assign i2c_sample  = phase >= I2C_SAMPLE_LO && phase <= I2C_TAIL1 && i2c_off[0];
  assign spi_sample  = phase >= SPI_SAMPLE_LO && phase <= SPI_SAMPLE_HI && spi_off[0];

  assign i2c_trail_rb = (trail == I2C_ACK)       ? I2C_ACK :
                        (trail == I2C_NACK_STOP) ? (ack_bit ? RB_NACK_STOP : RB_ACK_STOP) :
                        (ack_bit ? RB_SLAVE_NACK : RB_SLAVE_ACK);

  // Open-drain pins: value always low, enable pulls low
  assign select_out_pin_out    = 1'b0;
  assign data_io_pin_out       = 1'b0;
  assign clock_out_pin_out     = 1'b0;
  assign select_out_pin_oe_out = cs_low;
  assign data_io_pin_oe_out    = sda_low;
  assign clock_out_pin_oe_out  = scl_low;

  // Link synchronisers
  always_ff @(posedge host_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      arm_s <= 3'h0;
      sel_s <= 2'h3;
      din_s <= 2'h3;
    end else begin
      arm_s <= {arm_s[1:0], start_tgl};
      sel_s <= {sel_s[0], host_port_select_n_in};
      din_s <= {din_s[0], data_io_pin_in};
    end
  end

  // Slot and phase sequencing
  always_ff @(posedge host_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active <= 1'b0;
      slot   <= 2'h0;
      phase  <= 5'h00;
    end else if (arm_evt) begin
      active <= 1'b1;
      slot   <= 2'h0;
      phase  <= 5'h00;
    end else if (step) begin
      if (phase == PHASE_LAST) begin
        phase <= 5'h00;
        slot  <= slot + 2'h1;
        // Three slots of CYCLES_PER_SLOT cycles make one transfer
        if (slot == SLOT_LAST) begin
          active <= 1'b0;
        end
      end else begin
        phase <= phase + 5'h01;
      end
    end
  end

  // Result hand-off: written once per slot, then flagged by toggle
  always_ff @(posedge host_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      done_tgl  <= 1'b0;
      done_slot <= 2'h0;
      res_hi    <= 8'h00;
      res_lo    <= 8'h00;
    end else if (step && phase == PHASE_LAST) begin
      done_tgl  <= ~done_tgl;
      done_slot <= slot;
      if (spi_mode) begin
        res_hi <= {SPI_RB_LEAD, rx[7:4]};
        res_lo <= {rx[3:0], SPI_RB_TRAIL};
      end else begin
        res_hi <= {lead, rx[7:4]};
        res_lo <= {rx[3:0], i2c_trail_rb};
      end
    end
  end

  // Receive shift; skipped slots keep their payload
  always_ff @(posedge host_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx      <= 8'h00;
      ack_bit <= 1'b1;
    end else if (step) begin
      if (phase == 5'h00) begin
        rx <= data;
      end else if (!skip && !spi_mode && i2c_sample) begin
        if (phase == I2C_TAIL1) begin
          ack_bit <= din_s[1];
        end else begin
          rx <= {rx[6:0], din_s[1]};
        end
      end else if (!skip && spi_mode && spi_sample) begin
        rx <= {rx[6:0], din_s[1]};
      end
    end
  end

  // Pin sequencer: lines stay as left between transfers
  always_ff @(posedge host_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      skip    <= 1'b0;
      cs_low  <= 1'b0;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
    end else if (step) begin
      if (phase == 5'h00) begin
        skip <= 1'b0;
      end
      if (!spi_mode) begin
        // I2C master
        case (phase)
          5'h00: begin
            if (lead == I2C_START) begin
              sda_low <= 1'b0;
              scl_low <= 1'b0;
            end else if (lead == I2C_STOP) begin
              sda_low <= 1'b1;
              scl_low <= 1'b1;
            end else if (lead == I2C_NOTX) begin
              sda_low <= 1'b0;
              scl_low <= 1'b0;
              skip    <= 1'b1;
            end
            // Blank code goes straight to data
          end
          5'h01: begin
            if (lead == I2C_START) begin
              sda_low <= 1'b1;
            end else if (lead == I2C_STOP) begin
              scl_low <= 1'b0;
            end
          end
          5'h02: begin
            if (lead == I2C_START) begin
              scl_low <= 1'b1;
            end else if (lead == I2C_STOP) begin
              sda_low <= 1'b0;
              skip    <= 1'b1;
            end
          end
          default: begin
            if (skip) begin
              // Slot ignored, lines stay put
            end else if (in_i2c_bits) begin
              if (!i2c_off[0]) begin
                scl_low <= 1'b1;
                if (i2c_bit < 4'h8) begin
                  sda_low <= ~data[3'h7 - i2c_bit[2:0]];
                end else begin
                  sda_low <= (trail == I2C_ACK);
                end
              end else begin
                scl_low <= 1'b0;
              end
            end else if (phase == I2C_TAIL0) begin
              scl_low <= 1'b1;
              sda_low <= 1'b1;     // Held low between bytes
            end else if (phase == I2C_TAIL1 && trail == I2C_NACK_STOP) begin
              scl_low <= 1'b0;
            end else if (phase == I2C_TAIL2 && trail == I2C_NACK_STOP) begin
              sda_low <= 1'b0;
            end
          end
        endcase
      end else begin
        // SPI master, mode 3: clock idles released (high)
        case (phase)
          5'h00: begin
            scl_low <= 1'b0;
            if (lead == SPI_CS_LOW) begin
              cs_low <= 1'b1;
            end else if (lead == SPI_CS_FALL) begin
              cs_low <= 1'b0;
            end else if (lead == SPI_CS_HIGH || lead == SPI_NOTX) begin
              cs_low  <= 1'b0;
              sda_low <= 1'b0;
              skip    <= 1'b1;
            end
          end
          5'h01: begin
            if (lead == SPI_CS_FALL) begin
              cs_low <= 1'b1;
            end
          end
          default: begin
            if (skip) begin
              // Slot ignored, lines stay released
            end else if (in_spi_bits) begin
              if (!spi_off[0]) begin
                scl_low <= 1'b1;
                sda_low <= ~data[3'h7 - spi_bit];
              end else begin
                scl_low <= 1'b0;
              end
            end else if (phase == SPI_TAIL) begin
              sda_low <= 1'b0;
              if (trail == SPI_TR_CS_HIGH) begin
                cs_low <= 1'b0;
              end else if (trail[2:0] == 3'h0) begin
                cs_low <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// file: sim/aux_i2c_spi_master_checker.sv
`timescale 1ns/1ps
module aux_i2c_spi_master_checker (
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       buf_wr_en_in,
  input wire logic [2:0] buf_wr_index_in,
  input wire logic [7:0] buf_wr_data_in,
  input wire logic [2:0] buf_rd_index_in,
  input wire logic [7:0] buf_rd_data_out,
  input wire logic       start_bus_transfer_in,
  input wire logic       busy_out,
  input wire logic       host_clk_in,
  input wire logic       host_port_select_n_in,
  input wire logic       select_out_pin_out,
  input wire logic       select_out_pin_oe_out,
  input wire logic       data_io_pin_out,
  input wire logic       data_io_pin_oe_out,
  input wire logic       clock_out_pin_out,
  input wire logic       clock_out_pin_oe_out
);
  // Open drain: a pin value of one would fight the pull-ups
  a_pins_pull_low: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !select_out_pin_out && !data_io_pin_out && !clock_out_pin_out) else $error("pin drives high");
  // Unmapped byte indices read as zero
  a_unmapped_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    buf_rd_index_in > 3'h5 |=> buf_rd_data_out == 8'h00) else $error("unmapped read not zero");
  // A byte written while idle reads back two cycles later
  a_write_readback: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    buf_wr_en_in && buf_wr_index_in < 3'h6 && buf_wr_index_in == buf_rd_index_in && !busy_out
    ##1 $stable(buf_rd_index_in) && !buf_wr_en_in && !busy_out
    |=> buf_rd_data_out == $past(buf_wr_data_in, 2)) else $error("buffer readback wrong");
  // Start shows as busy on the next cycle
  a_start_busy: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    start_bus_transfer_in |=> busy_out) else $error("busy missing after start");
  // Pins move only on host edges counted while the host select is low
  a_counted_only: assert property (@(posedge host_clk_in) disable iff (sys_rst_in)
    $changed({select_out_pin_oe_out, data_io_pin_oe_out, clock_out_pin_oe_out})
    |-> !($past(host_port_select_n_in, 2) && $past(host_port_select_n_in, 3)
    && $past(host_port_select_n_in, 4))) else $error("pin moved on uncounted edge");
  // Mode 3: chip select falls only while the clock idles high
  a_cs_fall_clk_idle: assert property (@(posedge host_clk_in) disable iff (sys_rst_in)
    $rose(select_out_pin_oe_out) |-> !clock_out_pin_oe_out) else $error("cs fell, clock low");
  // Data must not move on the clock edge the slave samples
  a_data_hold_rise: assert property (@(posedge host_clk_in) disable iff (sys_rst_in)
    $fell(clock_out_pin_oe_out) && select_out_pin_oe_out |-> $stable(data_io_pin_oe_out))
    else $error("data moved on clock rise");
  // START: data falls with clock high, then the clock is pulled low
  a_i2c_start: assert property (@(posedge host_clk_in) disable iff (sys_rst_in)
    $rose(data_io_pin_oe_out) && !clock_out_pin_oe_out
    |=> clock_out_pin_oe_out && data_io_pin_oe_out) else $error("start not followed by scl low");
endmodule

bind aux_i2c_spi_master aux_i2c_spi_master_checker u_aux_i2c_spi_master_checker (
  .sys_clk_in, .sys_rst_in, .buf_wr_en_in, .buf_wr_index_in, .buf_wr_data_in,
  .buf_rd_index_in, .buf_rd_data_out, .start_bus_transfer_in, .busy_out, .host_clk_in,
  .host_port_select_n_in, .select_out_pin_out, .select_out_pin_oe_out, .data_io_pin_out,
  .data_io_pin_oe_out, .clock_out_pin_out, .clock_out_pin_oe_out);

// file: sim/aux_slave_model.sv
`timescale 1ns/1ps
module aux_slave_model (
  input  wire logic       spi_mode_in,  // 1: mode 3 SPI slave, 0: I2C slave
  input  wire logic       slave_ack_in, // Acknowledge on the ninth I2C clock
  input  wire logic [7:0] reply_in,     // Byte returned to the master
  input  wire logic       sel_line_in,  // Chip select line level
  input  wire logic       data_line_in, // Data line level
  input  wire logic       clk_line_in,  // Clock line level
  output logic            data_low_out, // Pulls the data line low
  output logic      [7:0] got_out       // Bits taken from the data line
);
  logic [3:0] bit_idx; // Bits since frame start; 9 means quiet
  initial begin
    bit_idx = 4'h9;
    data_low_out = 1'b0;
    got_out = 8'h00;
  end
  // START or chip select fall opens a frame
  // Look a moment later so a data change under a falling clock is no START
  always @(negedge data_line_in) #1 if (!spi_mode_in && clk_line_in && !data_line_in) bit_idx = 4'h0;
  always @(negedge sel_line_in) if (spi_mode_in) bit_idx = 4'h0;
  // Deselect releases the line, so it floats up to the pull-up
  always @(posedge sel_line_in) begin
    data_low_out = 1'b0;
    bit_idx = 4'h9;
  end
  // Sample on the rising clock, MSB first; I2C answers one byte only
  always @(posedge clk_line_in) begin
    if (bit_idx < 4'h8) got_out = {got_out[6:0], data_line_in};
    if (spi_mode_in) bit_idx = (bit_idx == 4'h7) ? 4'h0 : bit_idx + 4'h1;
    else if (bit_idx < 4'h9) bit_idx = bit_idx + 4'h1;
  end
  // Change data after the falling clock; ack on the ninth I2C bit
  always @(negedge clk_line_in) begin
    if (bit_idx < 4'h8) data_low_out = !reply_in[3'h7 - bit_idx[2:0]];
    else data_low_out = (bit_idx == 4'h8) && !spi_mode_in && slave_ack_in;
  end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import aux_master_pkg::*;
  logic       sys_clk, sys_rst, wr_en, check_fail, start, host_clk, host_sel_n;
  logic [2:0] wr_idx, rd_idx;
  logic [7:0] wr_data, rd_data, reply, got, cs_falls;
  logic       busy, spi_mode, slave_low;
  logic       sel_o, sel_oe, data_o, data_oe, clk_o, clk_oe;
  wire        sel_line, data_line, clk_line;
  int         bad_count, compares;
  // Pull-ups give the high level; the master may pull any line low, the slave only the data line
  assign sel_line  = sel_oe ? sel_o : 1'b1;
  assign data_line = (data_oe ? data_o : 1'b1) & !slave_low;
  assign clk_line  = clk_oe ? clk_o : 1'b1;
  aux_i2c_spi_master u_aux_i2c_spi_master (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
    .buf_wr_en_in(wr_en), .buf_wr_index_in(wr_idx), .buf_wr_data_in(wr_data),
    .check_fail_in(check_fail), .buf_rd_index_in(rd_idx), .buf_rd_data_out(rd_data),
    .start_bus_transfer_in(start), .busy_out(busy), .host_clk_in(host_clk),
    .host_port_select_n_in(host_sel_n), .select_out_pin_in(sel_line),
    .select_out_pin_out(sel_o), .select_out_pin_oe_out(sel_oe), .data_io_pin_in(data_line),
    .data_io_pin_out(data_o), .data_io_pin_oe_out(data_oe), .clock_out_pin_in(clk_line),
    .clock_out_pin_out(clk_o), .clock_out_pin_oe_out(clk_oe));
  aux_slave_model u_aux_slave_model (.spi_mode_in(spi_mode), .slave_ack_in(1'b1),
    .reply_in(reply), .sel_line_in(sel_line), .data_line_in(data_line),
    .clk_line_in(clk_line), .data_low_out(slave_low), .got_out(got));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Chip select falls seen on the wire
  always @(negedge sel_line) cs_falls = cs_falls + 8'h01;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] val);
    @(posedge sys_clk);
    #1 wr_en = 1'b1;
    wr_idx = idx;
    wr_data = val;
    @(posedge sys_clk);
    #1 wr_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
    @(posedge sys_clk);
    #1 rd_idx = idx;
    @(posedge sys_clk);
    #1 chk(rd_data, exp, "buffer byte");
  endtask
  task automatic load(input logic [47:0] v);
    for (int i = 0; i < 6; i++) wr(3'(i), v[47-8*i -: 8]);
  endtask
  task automatic rdall(input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) rd(3'(i), v[47-8*i -: 8]);
  endtask
  // Host clock runs in bursts of n cycles, also while select is high, and idles low between them
  task automatic host_run(input int n);
    repeat (n) begin
      #7.5 host_clk = 1'b1;
      #7.5 host_clk = 1'b0;
    end
  endtask
  // Start, arm the link side, then two sync edges plus slot 0
  task automatic begin_xfer;
    cs_falls = 8'h00;
    @(posedge sys_clk);
    #1 start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    host_run(4);
    host_sel_n = 1'b0;
    host_run(26);
  endtask
  task automatic end_xfer;
    int n;
    host_sel_n = 1'b1;
    host_run(3);
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    chk({7'h00, busy}, 8'h00, "busy");
  endtask
  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {wr_en, check_fail, start, host_clk, spi_mode} = 5'h00;
    {wr_idx, rd_idx, wr_data, reply} = 22'h000000;
    host_sel_n = 1'b1;
    sys_rst = 1'b1;
    cs_falls = 8'h00;
    fork
      host_run(3);
      repeat (10) @(posedge sys_clk);
    join
    #1 sys_rst = 1'b0;
    rdall(48'hffff_ffff_ffff, 6);
    rd(3'h6, 8'h00);
    chk({5'h00, sel_oe, data_oe, clk_oe}, 8'h00, "pins after reset");
    // Only defined codes are written: SPI slots 1000/1000, 1010/1001, 1001
    load(48'h8c58_aff9_9009);
    rdall(48'h8c58_aff9_9009, 6);
    // Failed check: buffer fills with ones once the host deselects
    @(posedge sys_clk);
    #1 check_fail = 1'b1;
    @(posedge sys_clk);
    #1 check_fail = 1'b0;
    host_sel_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 host_sel_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    rdall(48'hffff_ffff_ffff, 6);
    // SPI transfer; slave answers f6 on the shared data line
    load(48'h8c58_aff9_9009);
    spi_mode = 1'b1;
    reply = 8'hf6;
    begin_xfer();
    chk({7'h00, sel_oe}, 8'h01, "cs held low");
    chk(got, 8'hc4, "slave byte");
    host_run(24);
    chk({7'h00, sel_oe}, 8'h00, "cs high after byte");
    host_run(24);
    chk({6'h00, data_oe, clk_oe}, 8'h00, "spi lines released");
    chk(cs_falls, 8'h02, "cs falls");
    end_xfer();
    rdall(48'h7c4f_7f6f_0000, 4);
    // I2C transfer: START a0 NACK, blank ff ACK, STOP
    load(48'h6a08_0ff0_1000);
    spi_mode = 1'b0;
    reply = 8'hff;
    begin_xfer();
    chk(got, 8'ha0, "i2c slave byte");
    host_run(48);
    chk({6'h00, data_oe, clk_oe}, 8'h00, "i2c lines after stop");
    end_xfer();
    rdall(48'h6a07_0ff0_0000, 4);
    report_and_stop();
  end
endmodule
